// ---- pkg/hbs_pkg.sv ----
// Package for the handler bin sorting port: constants, register map, carriers
package hbs_pkg;
	localparam int          DATA_W       = 32;
	localparam int          MEAS_W       = 32;
	localparam int          NUM_BINS     = 6;
	localparam int          NUM_LIMITS   = 5;
	localparam logic [3:0]  ADDR_W       = 4'h4;
	// Register word indices (byte address is four times these)
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_STATUS   = 4'h1;
	localparam logic [3:0]  REG_RESULT   = 4'h2;
	localparam logic [3:0]  REG_LIMCNT   = 4'h3;
	localparam logic [3:0]  REG_LIM_BASE = 4'h4;
	localparam logic [3:0]  REG_DONE     = 4'h9;
	localparam logic [3:0]  REG_START    = 4'ha;
	// Control fields
	localparam int          CTRL_EXTTRIG = 0;
	localparam int          CTRL_CURMODE = 1;
	localparam int          CTRL_SEQPAGE = 2;
	localparam int          CTRL_FLASH   = 3;
	// Done register fields
	localparam int          DONE_FLASHOV = 0;
	// Bin numbers
	localparam logic [2:0]  BIN_ZERO     = 3'h0;
	localparam logic [2:0]  BIN_FOUR     = 3'h4;
	localparam logic [2:0]  BIN_FIVE     = 3'h5;
	localparam logic [2:0]  BIN_MAX      = 3'h5;
	localparam logic [5:0]  BINS_OFF     = 6'h3f;
	localparam logic [2:0]  LIMCNT_RST   = 3'h1;
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
	} hbs_bus_req_t;

	typedef struct packed {
		logic              waitrequest;
		logic [DATA_W-1:0] readdata;
	} hbs_bus_rsp_t;

	typedef struct packed {
		logic [NUM_BINS-1:0] bin_n;
		logic                trig_ready_n;
		logic                data_ready_n;
		logic                test_end_n;
		logic                voltage_on;
		logic                test_start;
	} hbs_handler_out_t;
endpackage

// ---- verilog/hbs_top.sv ----
// Handler port with bin sorting and an Avalon-MM register slave
`timescale 1ns/10ps
module hbs_top
	import hbs_pkg::*;
(
	// Clock and reset
	input  wire logic                       sys_clk_i,
	input  wire logic                       rstn_i,
	// Avalon-MM slave
	input  wire hbs_pkg::hbs_bus_req_t      bus_req_i,
	output hbs_pkg::hbs_bus_rsp_t           bus_rsp_o,
	// Handler inputs, active low
	input  wire logic                       external_trigger_n_i,
	input  wire logic                       voltage_break_n_i,
	// Measurement result from the measuring core
	input  wire logic [hbs_pkg::MEAS_W-1:0] meas_value_i,
	// Handler outputs
	output hbs_pkg::hbs_handler_out_t       handler_o
);
	import hbs_pkg::*;

	typedef enum logic [1:0] {
		HBS_IDLE = 2'b01,
		HBS_TEST = 2'b10
	} hbs_state_t;

	typedef struct packed {
		hbs_state_t                      state;
		logic [3:0]                      ctrl;
		logic [2:0]                      lim_cnt;
		logic [NUM_LIMITS-1:0][MEAS_W-1:0] lim;
		logic [2:0]                      bin;
		logic [MEAS_W-1:0]               result;
		logic                            trig_q;
		logic                            vbrk_q;
		logic                            sw_start;
		hbs_bus_rsp_t                    rsp;
		hbs_handler_out_t                hout;
	} hbs_all_t;

	hbs_all_t s;
	hbs_all_t next_s;

	// Count of limits strictly below the value gives the bin in ascending order
	function automatic logic [2:0] hbs_rank(input logic [MEAS_W-1:0] v,
		input logic [NUM_LIMITS-1:0][MEAS_W-1:0] l, input logic [2:0] n);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < NUM_LIMITS; i++) begin
			if ((3'(i) < n) && (v > l[i])) begin
				r = r + 3'h1;
			end
		end
		return r;
	endfunction

	// One-hot active-low bin vector
	function automatic logic [NUM_BINS-1:0] hbs_bin_n(input logic [2:0] b);
		logic [NUM_BINS-1:0] o;
		o = BINS_OFF;
		o[b] = 1'b0;
		return o;
	endfunction

	logic          trig_rise;
	logic          vbrk_rise;
	logic          done_wr;
	logic          flashover;
	logic [2:0]    rank;
	logic [2:0]    pick;
	logic [3:0]    loff;

	always_comb begin
		next_s = s;
		next_s.trig_q = external_trigger_n_i;
		next_s.vbrk_q = voltage_break_n_i;
		next_s.rsp.waitrequest = 1'b1;
		next_s.rsp.readdata = RD_ZERO;
		next_s.hout.data_ready_n = 1'b1;
		next_s.hout.test_start = 1'b0;
		next_s.sw_start = 1'b0;
		// Pin is active low: the handler's rising pulse is a falling pin level
		trig_rise = s.trig_q & ~external_trigger_n_i;
		vbrk_rise = s.vbrk_q & ~voltage_break_n_i;
		done_wr = 1'b0;
		flashover = 1'b0;
		loff = 4'h0;

		// Accept: waitrequest drops one cycle after the request is first seen, read data comes with it
		if ((bus_req_i.read | bus_req_i.write) & s.rsp.waitrequest) begin
			next_s.rsp.waitrequest = 1'b0;
			if (!bus_req_i.write) begin
				case (bus_req_i.address)
					REG_CTRL:   next_s.rsp.readdata = {28'h0, s.ctrl};
					REG_STATUS: next_s.rsp.readdata = {26'h0, s.hout.voltage_on, s.state, s.bin};
					REG_RESULT: next_s.rsp.readdata = s.result;
					REG_LIMCNT: next_s.rsp.readdata = {29'h0, s.lim_cnt};
					default: begin
						if (bus_req_i.address >= REG_LIM_BASE && bus_req_i.address < REG_DONE) begin
							loff = bus_req_i.address - REG_LIM_BASE;
							next_s.rsp.readdata = s.lim[loff[2:0]];
						end
					end
				endcase
			end
		end

		// Commit: a write lands only at the edge where the master sees waitrequest low
		if (bus_req_i.write & ~s.rsp.waitrequest) begin
				case (bus_req_i.address)
					REG_CTRL: begin
						next_s.ctrl = bus_req_i.writedata[3:0];
					end
					REG_LIMCNT: begin
						if (bus_req_i.writedata[2:0] <= 3'(NUM_LIMITS)) begin
							next_s.lim_cnt = bus_req_i.writedata[2:0];
						end
					end
					REG_DONE: begin
						done_wr = 1'b1;
						flashover = bus_req_i.writedata[DONE_FLASHOV];
					end
					REG_START: begin
						next_s.sw_start = 1'b1;
					end
					default: begin
						if (bus_req_i.address >= REG_LIM_BASE && bus_req_i.address < REG_DONE) begin
							loff = bus_req_i.address - REG_LIM_BASE;
							next_s.lim[loff[2:0]] = bus_req_i.writedata;
						end
					end
				endcase
		end

		if (vbrk_rise) begin
			next_s.hout.voltage_on = ~s.hout.voltage_on;
		end

		rank = hbs_rank(meas_value_i, s.lim, s.lim_cnt);
		pick = rank;
		if (s.ctrl[CTRL_SEQPAGE] | s.ctrl[CTRL_FLASH]) begin
			if (rank == 3'h0 || flashover) begin
				pick = BIN_ZERO;
			end else if (rank >= 3'h2) begin
				pick = BIN_FOUR;
			end else begin
				pick = BIN_FIVE;
			end
			if (s.ctrl[CTRL_FLASH]) begin
				pick = (flashover || rank == 3'h0) ? BIN_ZERO : BIN_FIVE;
			end
		end else if (s.lim_cnt == LIMCNT_RST) begin
			if (s.ctrl[CTRL_CURMODE]) begin
				pick = (rank == 3'h0) ? BIN_ZERO : BIN_FIVE;
			end else begin
				pick = (rank == 3'h0) ? BIN_ZERO : BIN_FIVE;
			end
		end else begin
			// Between limit one and two gives bin two, above that the next bins
			pick = (rank + 3'h1 > BIN_MAX) ? BIN_MAX : rank + 3'h1;
			if (rank == 3'h0) begin
				pick = BIN_ZERO;
			end
		end

		case (s.state)
			HBS_IDLE: begin
				next_s.hout.trig_ready_n = 1'b0;
				// Start on trigger edge or software start
				if ((s.ctrl[CTRL_EXTTRIG] & trig_rise) | (~s.ctrl[CTRL_EXTTRIG] & s.sw_start)) begin
					next_s.state = HBS_TEST;
					next_s.hout.trig_ready_n = 1'b1;
					next_s.hout.test_end_n = 1'b1;
					next_s.hout.test_start = 1'b1;
					// Bins released when next test starts
					next_s.hout.bin_n = BINS_OFF;
				end
			end
			HBS_TEST: begin
				next_s.hout.trig_ready_n = 1'b1;
				if (done_wr) begin
					next_s.state = HBS_IDLE;
					next_s.bin = pick;
					next_s.result = meas_value_i;
					next_s.hout.bin_n = hbs_bin_n(pick);
					// Data ready pulse and test end
					next_s.hout.data_ready_n = 1'b0;
					next_s.hout.test_end_n = 1'b0;
				end
			end
			default: begin
				next_s.state = HBS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
			s.state <= HBS_IDLE;
			s.lim_cnt <= LIMCNT_RST;
			s.trig_q <= 1'b1;
			s.vbrk_q <= 1'b1;
			s.rsp.waitrequest <= 1'b1;
			s.hout.bin_n <= BINS_OFF;
			s.hout.trig_ready_n <= 1'b1;
			s.hout.data_ready_n <= 1'b1;
			s.hout.test_end_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign bus_rsp_o = s.rsp;
	assign handler_o = s.hout;
endmodule

// ---- bench/hbs_sva.sv ----
// Assertion checker for the handler port
`timescale 1ns/10ps
module hbs_sva
	import hbs_pkg::*;
(
	// Clock and reset
	input wire logic                 sys_clk_i,
	input wire logic                 rstn_i,
	// Watched ports
	input wire hbs_bus_req_t         bus_req_i,
	input wire hbs_bus_rsp_t         bus_rsp_o,
	input wire logic                 external_trigger_n_i,
	input wire logic                 voltage_break_n_i,
	input wire logic [MEAS_W-1:0]    meas_value_i,
	input wire hbs_handler_out_t     handler_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_done;
		$fell(handler_o.data_ready_n);
	endsequence
	sequence s_ended;
		!handler_o.test_end_n ##1 !handler_o.test_end_n;
	endsequence
	property p_one_bin;
		!handler_o.test_end_n |-> $countones(~handler_o.bin_n) == 1;
	endproperty
	a_one_bin: assert property (p_one_bin) else $error("not one bin");
	property p_hold;
		s_ended |-> $stable(handler_o.bin_n);
	endproperty
	a_hold: assert property (p_hold) else $error("bin moved");
	property p_start;
		handler_o.test_start |-> handler_o.bin_n == BINS_OFF && handler_o.trig_ready_n && handler_o.test_end_n;
	endproperty
	a_start: assert property (p_start) else $error("start state");
	property p_pulse;
		handler_o.test_start |=> !handler_o.test_start;
	endproperty
	a_pulse: assert property (p_pulse) else $error("start too long");
	property p_drdy;
		s_done |=> handler_o.data_ready_n;
	endproperty
	a_drdy: assert property (p_drdy) else $error("ready too long");
	property p_end;
		s_done |-> !handler_o.test_end_n && handler_o.trig_ready_n ##1 !handler_o.trig_ready_n;
	endproperty
	a_end: assert property (p_end) else $error("end order");
	property p_volt;
		$fell(voltage_break_n_i) |=> handler_o.voltage_on != $past(handler_o.voltage_on);
	endproperty
	a_volt: assert property (p_volt) else $error("no toggle");
	property p_wait;
		(bus_req_i.read || bus_req_i.write) && bus_rsp_o.waitrequest |=> !bus_rsp_o.waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("slow answer");
endmodule
bind hbs_top hbs_sva chk_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus_req_i(bus_req_i),
	.bus_rsp_o(bus_rsp_o), .external_trigger_n_i(external_trigger_n_i),
	.voltage_break_n_i(voltage_break_n_i), .meas_value_i(meas_value_i), .handler_o(handler_o));

// ---- bench/hbs_hdl_model.sv ----
// Handler model driving the trigger and voltage break pins
`timescale 1ns/10ps
module hbs_hdl_model (
	// Clock
	input  wire logic clk_i,
	// Active-low pins
	output logic      trig_n_o = 1'b1,
	output logic      brk_n_o = 1'b1
);
	task automatic trig();
		@(posedge clk_i);
		trig_n_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		trig_n_o <= 1'b1;
	endtask
	task automatic brk();
		@(posedge clk_i);
		brk_n_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		brk_n_o <= 1'b1;
	endtask
endmodule

// ---- bench/hbs_tb_top.sv ----
// Testbench for the handler port
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] %0t got %0h want %0h", $time, (a), (b)); end end
module hbs_tb_top;
	import hbs_pkg::*;
	logic              sys_clk_i = 1'b0;
	logic              rstn_i = 1'b0;
	hbs_bus_req_t      req = '0;
	hbs_bus_rsp_t      rsp;
	logic [MEAS_W-1:0] meas = '0;
	hbs_handler_out_t  hout;
	logic              trig_n;
	logic              brk_n;
	logic [DATA_W-1:0] rd;
	int                err_total = 0;
	int                checks = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	hbs_top dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus_req_i(req), .bus_rsp_o(rsp),
		.external_trigger_n_i(trig_n), .voltage_break_n_i(brk_n), .meas_value_i(meas), .handler_o(hout));
	hbs_hdl_model hm_u (.clk_i(sys_clk_i), .trig_n_o(trig_n), .brk_n_o(brk_n));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [DATA_W-1:0] d);
		int n = 0;
		@(posedge sys_clk_i);
		req <= '{read: !w, write: w, address: a, writedata: d};
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (rsp.waitrequest !== 1'b0 && n < 20);
		rd = rsp.readdata;
		req <= '0;
		if (n >= 20) begin
			err_total++;
			stop_test();
		end
	endtask
	task automatic run(input logic ext, input logic [DATA_W-1:0] v, input logic fl, input logic [2:0] b);
		int n = 0;
		if (ext)
			hm_u.trig();
		else
			bus(1'b1, REG_START, RD_ZERO);
		meas <= v;
		bus(1'b1, REG_DONE, {31'h0, fl});
		// Data ready lasts one cycle: look just after the edge that launches it
		#1;
		while (hout.data_ready_n !== 1'b0 && n < 20) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		if (n >= 20) begin
			err_total++;
			stop_test();
		end
		`CHK(hout.data_ready_n, 1'b0)
		`CHK(hout.bin_n, ~(6'h1 << b))
		`CHK(hout.test_end_n, 1'b0)
		`CHK(hout.trig_ready_n, 1'b1)
		@(posedge sys_clk_i);
		#1;
		`CHK(hout.data_ready_n, 1'b1)
		`CHK(hout.trig_ready_n, 1'b0)
		`CHK(hout.bin_n, ~(6'h1 << b))
		$display("test done, bin %0d", b);
	endtask
	initial begin
		repeat (20) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		bus(1'b1, REG_CTRL, RD_ZERO);
		bus(1'b1, REG_LIMCNT, 32'h2);
		bus(1'b1, REG_LIM_BASE, 32'h64);
		bus(1'b1, REG_LIM_BASE + 4'h1, 32'hc8);
		run(1'b0, 32'h32, 1'b0, BIN_ZERO);
		run(1'b0, 32'h96, 1'b0, 3'h2);
		run(1'b0, 32'hfa, 1'b0, 3'h3);
		bus(1'b1, REG_CTRL, 32'h4);
		run(1'b0, 32'h32, 1'b0, BIN_ZERO);
		run(1'b0, 32'h96, 1'b0, BIN_FIVE);
		run(1'b0, 32'hfa, 1'b0, BIN_FOUR);
		bus(1'b1, REG_CTRL, 32'h9);
		run(1'b1, 32'h96, 1'b1, BIN_ZERO);
		run(1'b1, 32'h96, 1'b0, BIN_FIVE);
		run(1'b1, 32'h32, 1'b0, BIN_ZERO);
		bus(1'b1, REG_LIMCNT, 32'h1);
		bus(1'b1, REG_CTRL, RD_ZERO);
		run(1'b0, 32'h96, 1'b0, BIN_FIVE);
		bus(1'b1, REG_CTRL, 32'h2);
		run(1'b0, 32'h32, 1'b0, BIN_ZERO);
		bus(1'b0, REG_STATUS, RD_ZERO);
		`CHK(rd[2:0], BIN_ZERO)
		`CHK(rd[5:3], 3'h1)
		bus(1'b0, REG_RESULT, RD_ZERO);
		`CHK(rd, 32'h32)
		bus(1'b0, 4'hf, RD_ZERO);
		`CHK(rd, RD_ZERO)
		for (int i = 0; i < 2; i++) begin
			hm_u.brk();
			`CHK(hout.voltage_on, ~i[0])
		end
		$display("voltage test done");
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		err_total++;
		stop_test();
	end
endmodule
